// >>> hv_host_model.sv
`timescale 1ns/1ps

module hv_host_model (
    input wire logic clk,
    output logic sclk,
    output logic sdata,
    output logic latch_strobe_n
);
    logic busy;

    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        latch_strobe_n = 1'b1;
        busy = 1'b0;
    end

    // Idle data keeps moving so a stale bit cannot pass for data
    always @(negedge clk) begin
        if (!busy) begin
            sdata <= ~sdata;
        end
    end

    // ==========================================
    // One frame; sel low keeps the strobe high
    // ==========================================
    task automatic frame(input logic [31:0] w, input int n, input bit sel);
        busy = 1'b1;
        @(negedge clk);
        latch_strobe_n <= ~sel;
        repeat (3) @(negedge clk);
        for (int i = n - 1; i >= 0; i--) begin
            sclk <= 1'b1;
            @(negedge clk);
            sdata <= w[i];
            repeat (2) @(negedge clk);
            sclk <= 1'b0;
            repeat (3) @(negedge clk);
        end
        latch_strobe_n <= 1'b1;
        busy = 1'b0;
        repeat (7) @(negedge clk);
    endtask : frame
endmodule : hv_host_model

// >>> hv_latch_pkg.sv
package hv_latch_pkg;

    // ==========================================
    // Word geometry
    // ==========================================
    localparam int WORD_W = 24;
    localparam int CNT_W = 5;
    localparam int OUT_W_MAX = 21;
    localparam int SYNC_STAGES = 2;

    // ==========================================
    // Word routing
    // ==========================================
    localparam int SELECT_POS = 0;
    localparam logic SELECT_CONFIG = 1'b0;
    localparam logic SELECT_MASK = 1'b1;

    // ==========================================
    // Configuration field positions
    // ==========================================
    localparam int BOOST_V_LSB = 1;
    localparam int BOOST_V_W = 3;
    localparam int LIMIT_LSB = 4;
    localparam int LIMIT_W = 2;
    localparam int SOFT_OFF_POS = 6;
    localparam int SENSE_POS = 7;
    localparam int LIMIT_OFF_POS = 8;

    // Voltage code that parks the boost and floats the outputs
    localparam logic [2:0] BOOST_V_OFF = 3'h0;

    // ==========================================
    // Values after reset, and the full bit count
    // ==========================================
    localparam logic [23:0] SHIFT_RESET = 24'h000000;
    localparam logic [4:0] COUNT_RESET = 5'h00;
    localparam logic [4:0] COUNT_FULL = 5'h18;

    // ==========================================
    // Soft-start timing, 25 MHz clock
    // ==========================================
    localparam int CLK_PERIOD_NS = 40;
    localparam int SOFT_START_US = 1000;
    localparam int SOFT_START_CYCLES = (SOFT_START_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SS_CNT_W = 16;

    typedef struct packed {
        logic limit_disable;
        logic comparator_sense;
        logic soft_start_disable;
        logic [1:0] current_limit;
        logic [2:0] boost_voltage;
    } config_t;

    localparam config_t CONFIG_RESET = '{default: 1'b0};

    typedef struct packed {
        logic sclk;
        logic sdata;
        logic strobe_n;
        logic output_gate;
        logic soft_start_ext;
    } pins_t;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_RAMP = 2'b01,
        ST_RUN = 2'b10
    } boost_state_t;

endpackage : hv_latch_pkg

// >>> hv_output_shift_latch.sv
`timescale 1ns/1ps
// Function
// - Latch strobe is active low; bits clocked while it is high are ignored.
// - Strobe rising edge copies shift register into the addressed holding latch.
// - Serial data sampled on each falling serial clock edge while strobe low, except one in the same cycle as the strobe falling edge.
// - Three-byte shift register; new bits enter at lsb, move toward msb.
// - Strobe high disables the shift register so the bus may be shared.
// - Strobe falling edge clears the shift register and resumes shifting.
// - Holding latches keep value until new word or power-on reset.
// - Power-on reset clears every latch and zeroes the shift register.
// - Gate low drives outputs low; gate high outputs follow the mask.
// - Latched word with lsb zero goes to the configuration register.
// - Latched word with lsb one goes to the output-mask register.
// - Mask holds one bit per output, 19 or 21 bits by variant.
// - Configuration holds shutdown, boost voltage, current limit, soft start.
// - In shutdown or soft-start transient outputs float and gate is ignored.

module hv_output_shift_latch
    import hv_latch_pkg::*;
#(
    parameter int OUT_W = 21,
    parameter int SOFT_START_LEN = SOFT_START_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic latch_strobe_n,
    input wire logic output_gate,
    input wire logic soft_start_ext,
    output logic [OUT_W-1:0] hv_outputs,
    output logic [OUT_W-1:0] hv_outputs_oe,
    output hv_latch_pkg::config_t config_out,
    output logic [OUT_W-1:0] mask_out,
    output logic shutdown,
    output logic soft_start_busy,
    output logic config_loaded,
    output logic mask_loaded,
    output logic word_overrun,
    output logic [hv_latch_pkg::CNT_W-1:0] bit_count
);
    import hv_latch_pkg::*;

    // ==========================================
    // Helpers
    // ==========================================
    function automatic config_t unpack_config(input logic [WORD_W-1:0] w);
        config_t c;
        c.limit_disable = w[LIMIT_OFF_POS];
        c.comparator_sense = w[SENSE_POS];
        c.soft_start_disable = w[SOFT_OFF_POS];
        c.current_limit = w[LIMIT_LSB +: LIMIT_W];
        c.boost_voltage = w[BOOST_V_LSB +: BOOST_V_W];
        return c;
    endfunction : unpack_config

    function automatic logic is_shutdown(input config_t c);
        return c.boost_voltage == BOOST_V_OFF;
    endfunction : is_shutdown

    function automatic logic edge_fell(input logic prev, input logic now);
        return prev && !now;
    endfunction : edge_fell

    // ==========================================
    // Pin synchronisation
    // ==========================================
    pins_t pins_raw;
    pins_t pins_s;
    pins_t pins_idle;

    assign pins_raw = '{sclk: sclk, sdata: sdata, strobe_n: latch_strobe_n,
                        output_gate: output_gate, soft_start_ext: soft_start_ext};
    // Strobe idles high, else reset itself reads as a select and a latch
    assign pins_idle = '{
        sclk: 1'b0,
        sdata: 1'b0,
        strobe_n: 1'b1,
        output_gate: 1'b0,
        soft_start_ext: 1'b0
    };

    pin_sync #(
        .WIDTH($bits(pins_t))
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(pins_raw),
        .reset_val(pins_idle),
        .sync_out(pins_s)
    );

    // ==========================================
    // Edge detection on synchronised pins
    // ==========================================
    logic sclk_prev_q;
    logic strobe_prev_q;

    // Start as deselected so a low strobe after reset reads as a select
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sclk_prev_q <= 1'b0;
            strobe_prev_q <= 1'b1;
        end else begin
            sclk_prev_q <= pins_s.sclk;
            strobe_prev_q <= pins_s.strobe_n;
        end
    end

    logic sclk_fall;
    logic strobe_fall;
    logic strobe_rise;
    logic selected;

    // Edges show two clocks after the pin moves
    // active-low select
    assign selected = !pins_s.strobe_n;
    // falling-edge sample; data settled while clock high
    assign sclk_fall = edge_fell(sclk_prev_q, pins_s.sclk);
    assign strobe_fall = edge_fell(strobe_prev_q, pins_s.strobe_n);
    assign strobe_rise = !strobe_prev_q && pins_s.strobe_n;

    // ==========================================
    // Shift register
    // ==========================================
    logic shift_en;
    logic [WORD_W-1:0] shift_word;
    logic overrun;

    assign shift_en = sclk_fall && selected && !strobe_fall;

    serial_shifter #(
        .WIDTH(WORD_W)
    ) u_shift (
        .clk(clk),
        .rst_b(rst_b),
        .clear(strobe_fall),
        .shift(shift_en),
        .bit_in(pins_s.sdata),
        .shift_q(shift_word),
        .count_q(bit_count),
        .overflow_q(overrun)
    );

    // ==========================================
    // Holding latches
    // ==========================================
    config_t config_q;
    logic [OUT_W-1:0] mask_q;
    logic route_mask;

    assign route_mask = shift_word[SELECT_POS] == SELECT_MASK;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            config_q <= CONFIG_RESET;
        end else if (strobe_rise && !route_mask) begin
            config_q <= unpack_config(shift_word);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mask_q <= '0;
        // one bit per output above the select bit
        end else if (strobe_rise && route_mask) begin
            mask_q <= shift_word[OUT_W:1];
        end
    end

    // ==========================================
    // Load pulses and overrun report
    // ==========================================
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            config_loaded <= 1'b0;
            mask_loaded <= 1'b0;
        end else begin
            config_loaded <= strobe_rise && !route_mask;
            mask_loaded <= strobe_rise && route_mask;
        end
    end

    // report that early bits were dropped
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            word_overrun <= 1'b0;
        end else if (strobe_rise) begin
            word_overrun <= overrun;
        end
    end

    // ==========================================
    // Soft-start sequencer
    // ==========================================
    boost_state_t state_q;
    boost_state_t state_d;
    logic [SS_CNT_W-1:0] ramp_q;
    logic ramp_done;

    assign ramp_done = ramp_q == SS_CNT_W'(SOFT_START_LEN - 1);

    // Shutdown wins over ramp and run
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                if (!is_shutdown(config_q)) begin
                    state_d = config_q.soft_start_disable ? ST_RUN : ST_RAMP;
                end
            end
            ST_RAMP: begin
                if (is_shutdown(config_q)) begin
                    state_d = ST_OFF;
                end else if (ramp_done || config_q.soft_start_disable) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (is_shutdown(config_q)) begin
                    state_d = ST_OFF;
                end
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // Ramp timer restarts on every entry to the ramp
    always_ff @(posedge clk) begin
        if (!rst_b || state_q != ST_RAMP) begin
            ramp_q <= '0;
        end else if (!ramp_done) begin
            ramp_q <= ramp_q + 1'b1;
        end
    end

    // ==========================================
    // High-voltage outputs
    // ==========================================
    logic float_out;

    // analog ramp input also counts as a transient
    assign float_out = state_q != ST_RUN || pins_s.soft_start_ext;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hv_outputs_oe <= '0;
        end else begin
            hv_outputs_oe <= {OUT_W{!float_out}};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hv_outputs <= '0;
        end else if (float_out) begin
            hv_outputs <= '0;
        // gate low forces low, high applies mask
        end else begin
            hv_outputs <= pins_s.output_gate ? mask_q : '0;
        end
    end

    // ==========================================
    // Status flags
    // ==========================================
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            shutdown <= 1'b1;
        end else begin
            shutdown <= is_shutdown(config_q);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            soft_start_busy <= 1'b0;
        end else begin
            soft_start_busy <= state_q == ST_RAMP || pins_s.soft_start_ext;
        end
    end

    assign config_out = config_q;
    assign mask_out = mask_q;

endmodule : hv_output_shift_latch

// >>> hv_output_shift_latch_monitor.sv
`timescale 1ns/1ps

module hv_output_shift_latch_monitor
    import hv_latch_pkg::*;
#(
    parameter int OUT_W = 21
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic latch_strobe_n,
    input wire logic output_gate,
    input wire logic soft_start_ext,
    input wire logic [OUT_W-1:0] hv_outputs,
    input wire logic [OUT_W-1:0] hv_outputs_oe,
    input wire hv_latch_pkg::config_t config_out,
    input wire logic [OUT_W-1:0] mask_out,
    input wire logic shutdown,
    input wire logic soft_start_busy,
    input wire logic config_loaded,
    input wire logic mask_loaded,
    input wire logic word_overrun,
    input wire logic [hv_latch_pkg::CNT_W-1:0] bit_count
);
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // ==========================================
    // Output stage
    // ==========================================
    chk_out_mask: assert property (
        (hv_outputs & ~$past(mask_out)) == '0) else $error("Output high while its mask bit is clear");
    // Five low samples cover the two-flop pin delay
    chk_gate_low: assert property (
        !output_gate [*5] |-> hv_outputs == '0) else $error("Outputs not low with gate low");
    chk_float_low: assert property (
        (hv_outputs & ~hv_outputs_oe) == '0) else $error("Floating output shows a high level");
    chk_off_float: assert property (
        shutdown [*3] |-> hv_outputs_oe == '0) else $error("Outputs driven during shutdown");
    chk_ramp_float: assert property (
        soft_start_busy [*2] |-> hv_outputs_oe == '0) else $error("Outputs driven during soft start");

    // ==========================================
    // Latches and shifter
    // ==========================================
    chk_off_decode: assert property (
        $stable(config_out) [*2] |-> shutdown == (config_out.boost_voltage == BOOST_V_OFF))
        else $error("Shutdown flag disagrees with voltage field");
    chk_cfg_pulse: assert property (
        $changed(config_out) |-> config_loaded) else $error("Config changed without load pulse");
    chk_mask_pulse: assert property (
        $changed(mask_out) |-> mask_loaded) else $error("Mask changed without load pulse");
    chk_one_target: assert property (
        !(config_loaded && mask_loaded)) else $error("One word loaded into both latches");
    chk_cfg_hold: assert property (
        mask_loaded |-> $past(config_out) == $past(config_out, 2)) else $error("Mask load disturbed config");
    chk_count_step: assert property (
        $changed(bit_count) |-> bit_count == $past(bit_count) + 5'h01 || bit_count == COUNT_RESET)
        else $error("Bit count jumped");
    chk_count_cap: assert property (
        bit_count <= COUNT_FULL) else $error("Bit count above word width");

    cover property (config_loaded);
    cover property (mask_loaded && word_overrun);
    cover property (soft_start_busy ##1 !soft_start_busy);
endmodule : hv_output_shift_latch_monitor

bind hv_output_shift_latch hv_output_shift_latch_monitor #(.OUT_W(OUT_W)) u_mon (
    .clk(clk), .rst_b(rst_b), .sclk(sclk), .sdata(sdata), .latch_strobe_n(latch_strobe_n),
    .output_gate(output_gate), .soft_start_ext(soft_start_ext), .hv_outputs(hv_outputs),
    .hv_outputs_oe(hv_outputs_oe), .config_out(config_out), .mask_out(mask_out), .shutdown(shutdown),
    .soft_start_busy(soft_start_busy), .config_loaded(config_loaded), .mask_loaded(mask_loaded),
    .word_overrun(word_overrun), .bit_count(bit_count)
);

// >>> hv_output_shift_latch_tb.sv
`timescale 1ns/1ps

`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin n_mismatch++; \
    $display("Error %s expected %0h seen %0h", nm, e, s); end end

module hv_output_shift_latch_tb;
    import hv_latch_pkg::*;
    localparam int OUT_W = 21;
    logic clk, rst_b, output_gate, soft_start_ext, sclk, sdata, latch_strobe_n;
    logic [OUT_W-1:0] hv_outputs, hv_outputs_oe, mask_out;
    config_t config_out, cfg_exp;
    logic shutdown, soft_start_busy, config_loaded, mask_loaded, word_overrun;
    logic [CNT_W-1:0] bit_count;
    int n_tests = 0, n_mismatch = 0, n_mload = 0, n_cload = 0;

    hv_host_model host (.clk(clk), .sclk(sclk), .sdata(sdata), .latch_strobe_n(latch_strobe_n));

    // Short ramp keeps the run brief
    hv_output_shift_latch #(.OUT_W(OUT_W), .SOFT_START_LEN(8)) dut (
        .clk(clk), .rst_b(rst_b), .sclk(sclk), .sdata(sdata), .latch_strobe_n(latch_strobe_n),
        .output_gate(output_gate), .soft_start_ext(soft_start_ext), .hv_outputs(hv_outputs),
        .hv_outputs_oe(hv_outputs_oe), .config_out(config_out), .mask_out(mask_out), .shutdown(shutdown),
        .soft_start_busy(soft_start_busy), .config_loaded(config_loaded), .mask_loaded(mask_loaded),
        .word_overrun(word_overrun), .bit_count(bit_count)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(negedge clk) begin
        if (mask_loaded === 1'b1) n_mload++;
        if (config_loaded === 1'b1) n_cload++;
    end

    // ==========================================
    // Scenarios
    // ==========================================
    task automatic t_reset();
        `CHK("config", CONFIG_RESET, config_out)
        `CHK("mask", '0, mask_out)
        `CHK("shutdown", 1'b1, shutdown)
        `CHK("oe", '0, hv_outputs_oe)
        `CHK("count", COUNT_RESET, bit_count)
    endtask : t_reset

    task automatic t_config();
        logic [31:0] w;
        int c;
        w = 32'h000001AA;
        c = n_cload;
        cfg_exp = config_t'(w[8:1]);
        host.frame(w, 24, 1'b1);
        `CHK("config", cfg_exp, config_out)
        `CHK("config pulses", c + 1, n_cload)
        `CHK("shutdown", 1'b0, shutdown)
        `CHK("ramp", 1'b1, soft_start_busy)
        `CHK("oe ramp", '0, hv_outputs_oe)
        repeat (12) @(negedge clk);
        `CHK("ramp end", 1'b0, soft_start_busy)
        `CHK("oe run", '1, hv_outputs_oe)
        `CHK("out gate low", '0, hv_outputs)
    endtask : t_config

    task automatic t_mask();
        logic [OUT_W-1:0] m;
        int c;
        m = 21'h15A5C3;
        c = n_mload;
        output_gate <= 1'b1;
        host.frame({8'h00, 2'b00, m, 1'b1}, 24, 1'b1);
        `CHK("mask", m, mask_out)
        `CHK("mask pulses", c + 1, n_mload)
        `CHK("config kept", cfg_exp, config_out)
        `CHK("out", m, hv_outputs)
        `CHK("overrun", 1'b0, word_overrun)
        output_gate <= 1'b0;
        repeat (5) @(negedge clk);
        `CHK("out gate low", '0, hv_outputs)
        output_gate <= 1'b1;
        repeat (5) @(negedge clk);
        `CHK("out gate high", m, hv_outputs)
    endtask : t_mask

    task automatic t_overrun();
        logic [OUT_W-1:0] m;
        m = 21'h0F0F0F;
        host.frame({8'hFF, 2'b00, m, 1'b1}, 32, 1'b1);
        `CHK("mask long", m, mask_out)
        `CHK("overrun", 1'b1, word_overrun)
        `CHK("count sat", COUNT_FULL, bit_count)
    endtask : t_overrun

    task automatic t_short();
        host.frame(32'h00000081, 8, 1'b1);
        `CHK("mask short", 21'h000040, mask_out)
        `CHK("overrun", 1'b0, word_overrun)
        `CHK("out short", 21'h000040, hv_outputs)
        `CHK("count short", 5'h08, bit_count)
    endtask : t_short

    task automatic t_deselect();
        int c;
        c = n_mload;
        host.frame(32'h00FFFFFF, 24, 1'b0);
        `CHK("mask kept", 21'h000040, mask_out)
        `CHK("no pulse", c, n_mload)
    endtask : t_deselect

    task automatic t_float();
        soft_start_ext <= 1'b1;
        repeat (5) @(negedge clk);
        `CHK("oe transient", '0, hv_outputs_oe)
        `CHK("out transient", '0, hv_outputs)
        soft_start_ext <= 1'b0;
        repeat (5) @(negedge clk);
        `CHK("oe back", '1, hv_outputs_oe)
        host.frame(32'h00000000, 24, 1'b1);
        `CHK("shutdown on", 1'b1, shutdown)
        `CHK("oe off", '0, hv_outputs_oe)
        `CHK("mask kept", 21'h000040, mask_out)
        // Soft start disabled goes straight to driving
        host.frame(32'h00000042, 24, 1'b1);
        `CHK("config direct", config_t'(8'h21), config_out)
        `CHK("busy direct", 1'b0, soft_start_busy)
        `CHK("oe direct", '1, hv_outputs_oe)
        `CHK("out direct", 21'h000040, hv_outputs)
    endtask : t_float

    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        conclude();
    end

    initial begin
        rst_b = 1'b0;
        output_gate = 1'b0;
        soft_start_ext = 1'b0;
        repeat (10) @(negedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        t_reset();
        t_config();
        t_mask();
        t_overrun();
        t_short();
        t_deselect();
        t_float();
        rst_b <= 1'b0;
        repeat (3) @(negedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        t_reset();
        conclude();
    end
endmodule : hv_output_shift_latch_tb

// >>> pin_sync.sv
`timescale 1ns/1ps

module pin_sync #(
    parameter int WIDTH = 5
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    input wire logic [WIDTH-1:0] reset_val,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // ==========================================
    // Two-stage synchroniser
    // ==========================================
    // First stage feeds only the second stage
    // Reset to idle levels so no edge is seen after reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_q <= reset_val;
            sync_out <= reset_val;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : pin_sync

// >>> serial_shifter.sv
`timescale 1ns/1ps

module serial_shifter
    import hv_latch_pkg::*;
#(
    parameter int WIDTH = 24
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clear,
    input wire logic shift,
    input wire logic bit_in,
    output logic [WIDTH-1:0] shift_q,
    output logic [CNT_W-1:0] count_q,
    output logic overflow_q
);

    // ==========================================
    // Shift register
    // ==========================================
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            shift_q <= '0;
        end else if (clear) begin
            shift_q <= '0;
        // enter at lsb, oldest falls out
        end else if (shift) begin
            shift_q <= {shift_q[WIDTH-2:0], bit_in};
        end
    end

    // ==========================================
    // Bit count and overrun
    // ==========================================
    always_ff @(posedge clk) begin
        if (!rst_b || clear) begin
            count_q <= COUNT_RESET;
            overflow_q <= 1'b0;
        end else if (shift) begin
            if (count_q == COUNT_FULL) begin
                overflow_q <= 1'b1;
            end else begin
                count_q <= count_q + 5'h01;
            end
        end
    end

endmodule : serial_shifter
